// ===== lsar_regs.sv
// Module: per-port alias remap and link health status registers
// Notes on behaviour
// - Target address in 0x07 bits 7:1 remaps
// - Alias in 0x08 bits 7:1 selects target
// - Zero target or alias blocks remote access
// - Sixteen bit CRC counter read at 0x0A/0x0B
// - CRC error reset clears the counter
// - Sticky link lost until CRC reset
// - Selftest CRC flag, cleared by loss/restart/reset
// - Status bit 2 shows video clock present
// - Normal CRC flag, cleared by loss/reset
// - Status bit 0 shows link detected
// - Port select steers per-port registers
`timescale 1ns/1ns
module lsar_regs #(
  parameter int PORTS = 2
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SECOND_PORT_SELECT,
  input wire logic CRC_ERROR_RESET,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [PORTS-1:0] LINK_DETECT,
  input wire logic [PORTS-1:0] BACK_CRC_ERROR,
  input wire logic [PORTS-1:0] SELFTEST_ACTIVE,
  input wire logic [PORTS-1:0] SELFTEST_RESTART,
  input wire logic VIDEO_CLOCK_PRESENT,
  input wire logic REQ_VALID,
  input wire logic REQ_PORT,
  input wire logic [6:0] REQ_ADDR,
  output logic FWD_VALID,
  output logic FWD_HIT,
  output logic [6:0] FWD_ADDR
);
  // ********************
  // Pin synchronisers
  // ********************
  logic [PORTS-1:0] link_meta, link_sync, crc_meta, crc_sync;
  logic [PORTS-1:0] st_meta, st_sync, rs_meta, rs_sync;
  logic vclk_meta, vclk_sync;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      link_meta <= '0;
      link_sync <= '0;
      crc_meta <= '0;
      crc_sync <= '0;
      st_meta <= '0;
      st_sync <= '0;
      rs_meta <= '0;
      rs_sync <= '0;
      vclk_meta <= 1'b0;
      vclk_sync <= 1'b0;
    end else begin
      link_meta <= LINK_DETECT;
      link_sync <= link_meta;
      crc_meta <= BACK_CRC_ERROR;
      crc_sync <= crc_meta;
      st_meta <= SELFTEST_ACTIVE;
      st_sync <= st_meta;
      rs_meta <= SELFTEST_RESTART;
      rs_sync <= rs_meta;
      vclk_meta <= VIDEO_CLOCK_PRESENT;
      vclk_sync <= vclk_meta;
    end
  end

  // ********************
  // Per-port state
  // ********************
  logic [6:0] target [PORTS];
  logic [6:0] alias_addr [PORTS];
  logic [15:0] crc_count [PORTS];
  logic [PORTS-1:0] link_prev, link_lost, st_flag, nrm_flag;
  logic sel;
  assign sel = SECOND_PORT_SELECT;

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      logic loss;
      logic crc_ev;
      logic mine;
      assign loss = link_prev[p] && !link_sync[p];
      assign crc_ev = crc_sync[p] && link_sync[p];
      assign mine = (p == 1) ? sel : !sel;
      always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
          target[p] <= lsar_pkg::RST_ADDR7;
        end else if (REG_WR && mine && REG_ADDR == lsar_pkg::OFF_TARGET) begin
          target[p] <= REG_WDATA[7:1];
        end
      end
      always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
          alias_addr[p] <= lsar_pkg::RST_ADDR7;
        end else if (REG_WR && mine && REG_ADDR == lsar_pkg::OFF_ALIAS) begin
          alias_addr[p] <= REG_WDATA[7:1];
        end
      end
      always_ff @(posedge SYS_CLK) begin
        if (!NRST || CRC_ERROR_RESET) begin
          crc_count[p] <= lsar_pkg::RST_COUNT;
        end else if (crc_ev && crc_count[p] != lsar_pkg::COUNT_MAX) begin
          crc_count[p] <= crc_count[p] + 16'h0001;
        end
      end
      always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
          link_prev[p] <= 1'b0;
          link_lost[p] <= 1'b0;
        end else begin
          link_prev[p] <= link_sync[p];
          if (loss) begin
            link_lost[p] <= 1'b1;
          end else if (CRC_ERROR_RESET) begin
            link_lost[p] <= 1'b0;
          end
        end
      end
      always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
          st_flag[p] <= 1'b0;
        end else if (crc_ev && st_sync[p]) begin
          st_flag[p] <= 1'b1;
        end else if (loss || rs_sync[p] || CRC_ERROR_RESET) begin
          st_flag[p] <= 1'b0;
        end
      end
      always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
          nrm_flag[p] <= 1'b0;
        end else if (crc_ev && !st_sync[p]) begin
          nrm_flag[p] <= 1'b1;
        end else if (loss || CRC_ERROR_RESET) begin
          nrm_flag[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // ********************
  // Register read
  // ********************
  logic [7:0] next_rdata;
  logic sp;
  always_comb begin
    sp = sel && (PORTS > 1);
    next_rdata = lsar_pkg::RST_RDATA;
    if (REG_ADDR == lsar_pkg::OFF_TARGET) begin
      next_rdata = {target[sp], 1'b0};
    end else if (REG_ADDR == lsar_pkg::OFF_ALIAS) begin
      next_rdata = {alias_addr[sp], 1'b0};
    end else if (REG_ADDR == lsar_pkg::OFF_CRC_LOW) begin
      next_rdata = crc_count[sp][7:0];
    end else if (REG_ADDR == lsar_pkg::OFF_CRC_HIGH) begin
      next_rdata = crc_count[sp][15:8];
    end else if (REG_ADDR == lsar_pkg::OFF_STATUS) begin
      next_rdata[lsar_pkg::BIT_VIDEO_CLOCK] = vclk_sync;
      next_rdata[lsar_pkg::BIT_LINK_DETECT] = link_sync[sp];
      next_rdata[lsar_pkg::BIT_NORMAL_CRC] = nrm_flag[sp];
      next_rdata[lsar_pkg::BIT_SELFTEST_CRC] = st_flag[sp];
      next_rdata[lsar_pkg::BIT_LINK_LOST] = link_lost[sp];
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      REG_RDATA <= lsar_pkg::RST_RDATA;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  // ********************
  // Alias remap
  // ********************
  logic rp;
  logic hit;
  always_comb begin
    rp = REQ_PORT && (PORTS > 1);
    hit = (target[rp] != 7'h00) && (alias_addr[rp] != 7'h00) && (REQ_ADDR == alias_addr[rp]);
  end
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      FWD_VALID <= 1'b0;
      FWD_HIT <= 1'b0;
      FWD_ADDR <= lsar_pkg::RST_ADDR7;
    end else begin
      FWD_VALID <= REQ_VALID;
      FWD_HIT <= REQ_VALID && hit;
      FWD_ADDR <= hit ? target[rp] : REQ_ADDR;
    end
  end

  // ********************
  // Checks
  // ********************
  sequence s_loss0;
    link_prev[0] && !link_sync[0];
  endsequence
  AST_REMAP: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    REQ_VALID && hit |=> FWD_HIT && FWD_ADDR == $past(target[rp])) else $error("remap address wrong");
  AST_BLOCK: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    REQ_VALID && (target[rp] == 7'h00 || alias_addr[rp] == 7'h00) |=> !FWD_HIT) else $error("blocked hit");
  AST_ALIAS: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    FWD_HIT |-> FWD_VALID) else $error("hit without request");
  AST_MISS: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    REQ_VALID && REQ_ADDR != alias_addr[rp] |=> !FWD_HIT) else $error("hit on other address");
  AST_CNTCLR: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CRC_ERROR_RESET |=> crc_count[0] == 16'h0000) else $error("counter not cleared");
  AST_LOST: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    s_loss0 |=> link_lost[0] [*1] ##0 (link_lost[0] || $past(CRC_ERROR_RESET) == 1'b0)) else $error("lost not set");
  AST_STCLR: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    s_loss0 and !(crc_sync[0] && link_sync[0]) |=> !st_flag[0]) else $error("selftest flag kept");
  AST_NRMCLR: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CRC_ERROR_RESET && !(crc_sync[0] && link_sync[0]) |=> !nrm_flag[0]) else $error("normal flag kept");
  AST_RSVD: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    REG_RD && REG_ADDR == lsar_pkg::OFF_STATUS |=> REG_RDATA[7:5] == 3'h0) else $error("reserved nonzero");
  AST_CNT: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    REG_RD && REG_ADDR == lsar_pkg::OFF_CRC_HIGH |=> REG_RDATA == $past(crc_count[sp][15:8])) else $error("count read");
endmodule : lsar_regs

// ===== lsar_pkg.sv
// Package: offsets, field positions and reset values of the link status and alias registers
package lsar_pkg;
  // ********************
  // Register offsets
  // ********************
  localparam logic [7:0] OFF_TARGET = 8'h07;
  localparam logic [7:0] OFF_ALIAS = 8'h08;
  localparam logic [7:0] OFF_CRC_LOW = 8'h0a;
  localparam logic [7:0] OFF_CRC_HIGH = 8'h0b;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  // ********************
  // Status field positions
  // ********************
  localparam int BIT_LINK_DETECT = 0;
  localparam int BIT_NORMAL_CRC = 1;
  localparam int BIT_VIDEO_CLOCK = 2;
  localparam int BIT_SELFTEST_CRC = 3;
  localparam int BIT_LINK_LOST = 4;
  // ********************
  // Reset values and counter limit
  // ********************
  localparam logic [6:0] RST_ADDR7 = 7'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage : lsar_pkg

// ===== lsar_far_end.sv
// Remote end model driving link and error pins
`timescale 1ns/1ns
module lsar_far_end (
  input wire logic SYS_CLK,
  output logic [1:0] LINK_DETECT,
  output logic [1:0] BACK_CRC_ERROR,
  output logic [1:0] SELFTEST_ACTIVE,
  output logic [1:0] SELFTEST_RESTART
);
  initial begin
    LINK_DETECT = 2'h0;
    BACK_CRC_ERROR = 2'h0;
    SELFTEST_ACTIVE = 2'h0;
    SELFTEST_RESTART = 2'h0;
  end
  // One error per cycle high
  task errs(input int p, input int n);
    BACK_CRC_ERROR[p] = 1'b1;
    repeat (n) @(posedge SYS_CLK);
    #1;
    BACK_CRC_ERROR[p] = 1'b0;
  endtask : errs
  // Link detect levels per port
  task link(input logic [1:0] v);
    LINK_DETECT = v;
  endtask : link
  // Selftest active levels per port
  task selftest(input logic [1:0] v);
    SELFTEST_ACTIVE = v;
  endtask : selftest
  // Restart pulse one cycle wide
  task restart(input int p);
    SELFTEST_RESTART[p] = 1'b1;
    @(posedge SYS_CLK);
    #1;
    SELFTEST_RESTART[p] = 1'b0;
  endtask : restart
endmodule : lsar_far_end

// ===== lsar_regs_bench.sv
// Testbench for link status and alias registers
`timescale 1ns/1ns
module lsar_regs_bench;
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic SECOND_PORT_SELECT = 1'b0;
  logic CRC_ERROR_RESET = 1'b0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic [7:0] REG_RDATA;
  logic [1:0] LINK_DETECT, BACK_CRC_ERROR, SELFTEST_ACTIVE, SELFTEST_RESTART;
  logic VIDEO_CLOCK_PRESENT = 1'b0;
  logic REQ_VALID = 1'b0;
  logic REQ_PORT = 1'b0;
  logic [6:0] REQ_ADDR = 7'h00;
  logic FWD_VALID, FWD_HIT;
  logic [6:0] FWD_ADDR;
  int err_count = 0;
  int tests_run = 0;
  lsar_regs u_lsar_regs (.SYS_CLK, .NRST, .SECOND_PORT_SELECT, .CRC_ERROR_RESET, .REG_WR, .REG_RD, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .LINK_DETECT, .BACK_CRC_ERROR, .SELFTEST_ACTIVE, .SELFTEST_RESTART,
    .VIDEO_CLOCK_PRESENT, .REQ_VALID, .REQ_PORT, .REQ_ADDR, .FWD_VALID, .FWD_HIT, .FWD_ADDR);
  lsar_far_end u_lsar_far_end (.SYS_CLK, .LINK_DETECT, .BACK_CRC_ERROR, .SELFTEST_ACTIVE, .SELFTEST_RESTART);
  // ****
  // Helpers
  // ****
  task stop_test();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [7:0] d);
    REG_RD = 1'b0;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    tick(1);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    REG_WR = 1'b0;
    REG_ADDR = a;
    REG_RD = 1'b1;
    tick(1);
    chk("rdata", {a, e}, {a, REG_RDATA});
  endtask : rd
  task req(input logic p, input logic [6:0] a, input logic h, input logic [6:0] f);
    REQ_PORT = p;
    REQ_ADDR = a;
    REQ_VALID = 1'b1;
    tick(1);
    chk("fwd", {1'b1, h, f}, {FWD_VALID, FWD_HIT, FWD_ADDR});
  endtask : req
  task idle();
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REQ_VALID = 1'b0;
    tick(1);
  endtask : idle
  task clr();
    CRC_ERROR_RESET = 1'b1;
    tick(1);
    CRC_ERROR_RESET = 1'b0;
    tick(1);
  endtask : clr
  // ****
  // Scenarios
  // ****
  task t_alias();
    rd(8'h05, 8'h00);
    wr(8'h08, 8'h43);
    rd(8'h08, 8'h42);
    req(1'b0, 7'h21, 1'b0, 7'h21);
    wr(8'h07, 8'hab);
    wr(8'h0c, 8'hff);
    rd(8'h07, 8'haa);
    rd(8'h0c, 8'h00);
    req(1'b0, 7'h21, 1'b1, 7'h55);
    req(1'b0, 7'h22, 1'b0, 7'h22);
    req(1'b1, 7'h21, 1'b0, 7'h21);
    SECOND_PORT_SELECT = 1'b1;
    rd(8'h07, 8'h00);
    wr(8'h07, 8'h22);
    wr(8'h08, 8'h31);
    rd(8'h08, 8'h30);
    SECOND_PORT_SELECT = 1'b0;
    rd(8'h07, 8'haa);
    req(1'b1, 7'h18, 1'b1, 7'h11);
    idle();
  endtask : t_alias
  task t_crc();
    u_lsar_far_end.link(2'h3);
    tick(4);
    u_lsar_far_end.errs(0, 259);
    tick(3);
    rd(8'h0a, 8'h03);
    rd(8'h0b, 8'h01);
    rd(8'h0c, 8'h03);
    SECOND_PORT_SELECT = 1'b1;
    rd(8'h0a, 8'h00);
    rd(8'h0c, 8'h01);
    SECOND_PORT_SELECT = 1'b0;
    u_lsar_far_end.selftest(2'h1);
    tick(3);
    u_lsar_far_end.errs(0, 1);
    tick(3);
    rd(8'h0c, 8'h0b);
    u_lsar_far_end.restart(0);
    tick(3);
    rd(8'h0c, 8'h03);
    u_lsar_far_end.selftest(2'h0);
    clr();
    rd(8'h0a, 8'h00);
    rd(8'h0c, 8'h01);
    idle();
  endtask : t_crc
  task t_loss();
    VIDEO_CLOCK_PRESENT = 1'b1;
    u_lsar_far_end.errs(0, 1);
    tick(3);
    u_lsar_far_end.selftest(2'h1);
    tick(3);
    u_lsar_far_end.errs(0, 1);
    tick(3);
    rd(8'h0c, 8'h0f);
    u_lsar_far_end.link(2'h2);
    tick(10);
    rd(8'h0c, 8'h14);
    u_lsar_far_end.selftest(2'h0);
    u_lsar_far_end.link(2'h3);
    tick(4);
    rd(8'h0c, 8'h15);
    clr();
    rd(8'h0c, 8'h05);
    idle();
  endtask : t_loss
  task t_reset();
    u_lsar_far_end.errs(0, 1);
    tick(3);
    NRST = 1'b0;
    tick(5);
    NRST = 1'b1;
    tick(2);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h0a, 8'h00);
    idle();
  endtask : t_reset
  initial forever #5 SYS_CLK = ~SYS_CLK;
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge SYS_CLK);
    #1;
    NRST = 1'b1;
    tick(2);
    t_alias();
    t_crc();
    t_loss();
    t_reset();
    stop_test();
  end
endmodule : lsar_regs_bench
